// file: hw/spi_port_pkg.sv
// Constants and state types for the serial peripheral port of the impedance front end
package spi_port_pkg;
    // Field widths
    localparam int unsigned CNT_W = 6;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned CMD_W = 8;
    localparam int unsigned DATA_W = 24;
    localparam int unsigned SYNC_W = 3;

    // Rising edge numbers within a frame
    localparam logic [CNT_W-1:0] EDGE_FIRST = 6'h01;
    localparam logic [CNT_W-1:0] EDGE_STEP = 6'h01;
    localparam logic [CNT_W-1:0] EDGE_ADDR_DONE = 6'h07;
    localparam logic [CNT_W-1:0] EDGE_CMD_DONE = 6'h08;
    localparam logic [CNT_W-1:0] EDGE_UPDATE = 6'h1E;
    localparam logic [CNT_W-1:0] EDGE_LAST = 6'h20;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;

    // Command decode
    localparam logic [ADDR_W-1:0] ADDR_NOP_LO = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_BURST = 7'h22;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_NORMAL = 7'h23;
    localparam logic [ADDR_W-1:0] ADDR_NOP_HI = 7'h7F;
    localparam logic READ_FLAG = 1'b1;

    // Reset values
    localparam logic [DATA_W-1:0] ZERO_WORD = 24'h000000;
    localparam logic [CMD_W-1:0] ZERO_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] ZERO_ADDR = 7'h00;
    localparam logic [SYNC_W-1:0] ZERO_SYNC = 3'h0;

    // Link-domain state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CMD_W-1:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic done;
        logic [DATA_W-1:0] shin;
        logic [DATA_W-1:0] shout;
        logic sdo;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic wr_tgl;
        logic pop_tgl;
        logic st_tgl;
        logic [SYNC_W-1:0] hv;
        logic has_data;
    } link_state_t;

    // System-domain state
    typedef struct packed {
        logic [SYNC_W-1:0] wr_s;
        logic [SYNC_W-1:0] pop_s;
        logic [SYNC_W-1:0] st_s;
        logic wr_seen;
        logic pop_seen;
        logic st_seen;
        logic wr_stb;
        logic pop_stb;
        logic st_stb;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
    } sys_state_t;

    // Frame start marker state
    typedef struct packed {
        logic fresh;
    } frame_state_t;
endpackage : spi_port_pkg

// file: hw/spi_slave_fifo_readback.sv
// Serial peripheral port: frame decode on the link clock, event hand-off to the system clock
`timescale 1ns/1ps

// Marks the first rising edge of each frame; chip select high sets it
// Set without the serial clock, which stands still between frames
// Chip select idles high, so the mark is set before any frame
module spi_frame_mark (
    input wire logic sclk,
    input wire logic cs_n,
    output logic fresh
);
    import spi_port_pkg::*;

    frame_state_t s;
    frame_state_t next_s;

    // Cleared by the first clock of a frame
    always_comb begin
        next_s = s;
        next_s.fresh = 1'b0;
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            s.fresh <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign fresh = s.fresh;
endmodule : spi_frame_mark

// Link-side frame engine, clocked by the host's serial clock
module spi_link_side (
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic fresh,
    input wire logic sdi,
    input wire logic [spi_port_pkg::DATA_W-1:0] rd_data,
    input wire logic fifo_has_data,
    output logic sdo,
    output logic [spi_port_pkg::ADDR_W-1:0] rd_addr,
    output logic [spi_port_pkg::ADDR_W-1:0] wr_addr,
    output logic [spi_port_pkg::DATA_W-1:0] wr_data,
    output logic wr_tgl,
    output logic pop_tgl,
    output logic st_tgl
);
    import spi_port_pkg::*;

    // Frame engine state and decode helpers
    link_state_t s;
    link_state_t next_s;
    logic [CNT_W-1:0] edge_no;
    logic done_now;
    logic is_nop;
    logic is_fifo;
    logic [DATA_W-1:0] load_word;

    // Address class of the current command
    // no-op address pair
    assign is_nop = (s.addr == ADDR_NOP_LO) || (s.addr == ADDR_NOP_HI);
    assign is_fifo = (s.addr == ADDR_FIFO_BURST) || (s.addr == ADDR_FIFO_NORMAL);

    // Next state of the frame engine
    always_comb begin
        next_s = s;
        load_word = ZERO_WORD;

        // Three-stage filter on the FIFO level
        // Core level changes between serial clock edges
        next_s.hv = {s.hv[SYNC_W-2:0], fifo_has_data};
        if (s.hv[1] == s.hv[2]) begin
            next_s.has_data = s.hv[2];
        end

        done_now = fresh ? 1'b0 : s.done;
        edge_no = fresh ? EDGE_FIRST : s.cnt + EDGE_STEP;
        if (fresh) begin
            next_s.rd = 1'b0;
            next_s.sdo = 1'b0;
            next_s.shout = ZERO_WORD;
        end

        // edges past the end do nothing
        if (done_now) begin
            next_s.sdo = 1'b0;
        end else begin
            next_s.cnt = edge_no;
            if (edge_no <= EDGE_CMD_DONE) begin
                next_s.cmd = {s.cmd[CMD_W-2:0], sdi};
            end else begin
                next_s.shin = {s.shin[DATA_W-2:0], sdi};
            end
            if (edge_no == EDGE_ADDR_DONE) begin
                next_s.addr = {s.cmd[ADDR_W-2:0], sdi};
            end
            // Read word latched at end of command
            if (edge_no == EDGE_CMD_DONE) begin
                // last command bit is read flag
                next_s.rd = (sdi == READ_FLAG);
                if ((sdi == READ_FLAG) && !is_nop) begin
                    load_word = rd_data;
                end
                next_s.sdo = load_word[DATA_W-1];
                next_s.shout = {load_word[DATA_W-2:0], 1'b0};
            end else if (edge_no > EDGE_CMD_DONE) begin
                next_s.sdo = s.shout[DATA_W-1];
                next_s.shout = {s.shout[DATA_W-2:0], 1'b0};
            end
            if ((edge_no == EDGE_UPDATE) && s.rd) begin
                if (is_fifo) begin
                    next_s.pop_tgl = ~s.pop_tgl;
                end
                if (s.addr == ADDR_STATUS) begin
                    next_s.st_tgl = ~s.st_tgl;
                end
            end
            if (edge_no == EDGE_LAST) begin
                if (!s.rd) begin
                    if (!is_nop) begin
                        next_s.wr_addr = s.addr;
                        next_s.wr_data = {s.shin[DATA_W-2:0], sdi};
                        next_s.wr_tgl = ~s.wr_tgl;
                    end
                    next_s.done = 1'b1;
                    next_s.sdo = 1'b0;
                end else if ((s.addr == ADDR_FIFO_BURST) && s.has_data) begin
                    // Core must show the next head by now
                    // next word MSB follows
                    load_word = rd_data;
                    next_s.sdo = load_word[DATA_W-1];
                    next_s.shout = {load_word[DATA_W-2:0], 1'b0};
                    next_s.cnt = EDGE_CMD_DONE;
                end else begin
                    next_s.done = 1'b1;
                    next_s.sdo = 1'b0;
                end
            end
        end
        // A new frame clears the end marker
        if (fresh) begin
            next_s.done = (edge_no > EDGE_LAST);
        end
    end

    // Link-domain register; cleared by system reset
    // Serial clock must stand still while reset is low
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            s.cnt <= CNT_RESET;
            s.cmd <= ZERO_CMD;
            s.addr <= ZERO_ADDR;
            s.rd <= 1'b0;
            s.done <= 1'b0;
            s.shin <= ZERO_WORD;
            s.shout <= ZERO_WORD;
            s.sdo <= 1'b0;
            s.wr_addr <= ZERO_ADDR;
            s.wr_data <= ZERO_WORD;
            s.wr_tgl <= 1'b0;
            s.pop_tgl <= 1'b0;
            s.st_tgl <= 1'b0;
            s.hv <= ZERO_SYNC;
            s.has_data <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign sdo = s.sdo;
    assign rd_addr = s.addr;
    assign wr_addr = s.wr_addr;
    assign wr_data = s.wr_data;
    assign wr_tgl = s.wr_tgl;
    assign pop_tgl = s.pop_tgl;
    assign st_tgl = s.st_tgl;
endmodule : spi_link_side

// Contract
// - Sample input on each rising clock edge
// - Frame is 32 clocks under chip select
// - Command byte: seven address bits, read flag
// - Three data bytes follow every command
// - Works in mode 0 and mode 3
// - Write commits on edge 32
// - Bits after edge 32 ignored in writes
// - Early chip select rise cancels command
// - Fetch at edge 8, MSB before edge 9
// - Normal read past 32 outputs zeros
// - Status and FIFO update on edge 30
// - Burst read has its own address
// - Burst next word sampled at edge 32
// - Updates on edge 30 plus 24n
// - Burst continues while FIFO has data
// - No burst writes; one register each
// - Burst at 0x22, normal at 0x23
// - No-op addresses read zero, ignore writes
module spi_slave_fifo_readback (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic LINK_SCLK,
    input wire logic CHIP_SELECT_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE_N,
    output logic [spi_port_pkg::ADDR_W-1:0] REG_RD_ADDR,
    input wire logic [spi_port_pkg::DATA_W-1:0] REG_RD_DATA,
    input wire logic FIFO_HAS_DATA,
    output logic REG_WR_STB,
    output logic [spi_port_pkg::ADDR_W-1:0] REG_WR_ADDR,
    output logic [spi_port_pkg::DATA_W-1:0] REG_WR_DATA,
    output logic FIFO_POP_STB,
    output logic STATUS_UPD_STB
);
    import spi_port_pkg::*;

    sys_state_t s;
    sys_state_t next_s;
    logic fresh;
    // Toggles and write word from the link side
    logic link_wr_tgl;
    logic link_pop_tgl;
    logic link_st_tgl;
    logic [ADDR_W-1:0] link_wr_addr;
    logic [DATA_W-1:0] link_wr_data;
    // One-cycle events in the system domain
    logic wr_evt;
    logic pop_evt;
    logic st_evt;

    spi_frame_mark u_mark (
        .sclk(LINK_SCLK),
        .cs_n(CHIP_SELECT_N),
        .fresh(fresh)
    );

    // both modes sample on rising edges
    spi_link_side u_link (
        .sclk(LINK_SCLK),
        .rst_b(RST_B),
        .fresh(fresh),
        .sdi(SDI),
        .rd_data(REG_RD_DATA),
        .fifo_has_data(FIFO_HAS_DATA),
        .sdo(SDO),
        .rd_addr(REG_RD_ADDR),
        .wr_addr(link_wr_addr),
        .wr_data(link_wr_data),
        .wr_tgl(link_wr_tgl),
        .pop_tgl(link_pop_tgl),
        .st_tgl(link_st_tgl)
    );

    // Output driven only inside a frame
    assign SDO_OE_N = CHIP_SELECT_N;

    // Toggle counts once stages two and three agree
    // A toggle cannot be lost however the clocks align
    assign wr_evt = (s.wr_s[1] == s.wr_s[2]) && (s.wr_s[2] != s.wr_seen);
    assign pop_evt = (s.pop_s[1] == s.pop_s[2]) && (s.pop_s[2] != s.pop_seen);
    assign st_evt = (s.st_s[1] == s.st_s[2]) && (s.st_s[2] != s.st_seen);

    // Next state of the system-side hand-off
    always_comb begin
        next_s = s;
        // Toggles shift through three stages
        next_s.wr_s = {s.wr_s[SYNC_W-2:0], link_wr_tgl};
        next_s.pop_s = {s.pop_s[SYNC_W-2:0], link_pop_tgl};
        next_s.st_s = {s.st_s[SYNC_W-2:0], link_st_tgl};

        // Strobes last one system clock
        next_s.wr_stb = wr_evt;
        next_s.pop_stb = pop_evt;
        next_s.st_stb = st_evt;

        // Write word settled before its toggle arrives
        // hand committed write over
        if (wr_evt) begin
            next_s.wr_seen = s.wr_s[2];
            next_s.wr_addr = link_wr_addr;
            next_s.wr_data = link_wr_data;
        end
        if (pop_evt) begin
            next_s.pop_seen = s.pop_s[2];
        end
        if (st_evt) begin
            next_s.st_seen = s.st_s[2];
        end
    end

    // System register with synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            s.wr_s <= ZERO_SYNC;
            s.pop_s <= ZERO_SYNC;
            s.st_s <= ZERO_SYNC;
            s.wr_seen <= 1'b0;
            s.pop_seen <= 1'b0;
            s.st_seen <= 1'b0;
            s.wr_stb <= 1'b0;
            s.pop_stb <= 1'b0;
            s.st_stb <= 1'b0;
            s.wr_addr <= ZERO_ADDR;
            s.wr_data <= ZERO_WORD;
        end else begin
            s <= next_s;
        end
    end

    // Strobes and write word from flip-flops
    assign REG_WR_STB = s.wr_stb;
    assign REG_WR_ADDR = s.wr_addr;
    assign REG_WR_DATA = s.wr_data;
    assign FIFO_POP_STB = s.pop_stb;
    assign STATUS_UPD_STB = s.st_stb;
endmodule : spi_slave_fifo_readback

// file: bench/spi_port_monitor.sv
// Checker for strobes and serial output of the port
`timescale 1ns/1ps
module spi_port_monitor (
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic LINK_SCLK,
    input wire logic CHIP_SELECT_N,
    input wire logic SDI,
    input wire logic SDO,
    input wire logic SDO_OE_N,
    input wire logic [spi_port_pkg::DATA_W-1:0] REG_RD_DATA,
    input wire logic REG_WR_STB,
    input wire logic [spi_port_pkg::ADDR_W-1:0] REG_WR_ADDR,
    input wire logic [spi_port_pkg::DATA_W-1:0] REG_WR_DATA,
    input wire logic FIFO_POP_STB,
    input wire logic STATUS_UPD_STB
);
    import spi_port_pkg::*;
    logic [CNT_W-1:0] cnt;
    logic [CMD_W-1:0] cmd;
    logic rd_ph;
    logic nop;
    // Frame edge count and command capture
    always_ff @(posedge LINK_SCLK or posedge CHIP_SELECT_N) begin
        if (CHIP_SELECT_N) begin
            cnt <= CNT_RESET;
            cmd <= ZERO_CMD;
        end else begin
            if (cnt != 6'h3F) cnt <= cnt + EDGE_STEP;
            if (cnt < EDGE_CMD_DONE) cmd <= {cmd[6:0], SDI};
        end
    end
    // Read data phase and no-op decode
    assign rd_ph = !CHIP_SELECT_N && cmd[0] == READ_FLAG && cnt >= EDGE_CMD_DONE;
    assign nop = cmd[7:1] == ADDR_NOP_LO || cmd[7:1] == ADDR_NOP_HI;
    // Serial output, sampled mid-bit
    a_sdo_msb_first: assert property (@(negedge LINK_SCLK) disable iff (!RST_B)
        rd_ph && !nop && cnt < EDGE_UPDATE |-> SDO == REG_RD_DATA[5'h1F - cnt[4:0]]) else $error("read bit wrong");
    a_nop_read_zero: assert property (@(negedge LINK_SCLK) disable iff (!RST_B)
        rd_ph && nop |-> !SDO) else $error("no-op read not zero");
    a_read_tail_zero: assert property (@(negedge LINK_SCLK) disable iff (!RST_B)
        rd_ph && cmd[7:1] != ADDR_FIFO_BURST && cnt >= EDGE_LAST |-> !SDO) else $error("read tail not zero");
    // Output enable, core-side strobes and write values
    a_oe_follows_cs: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        SDO_OE_N == CHIP_SELECT_N) else $error("output enable off frame");
    // Strobes stay low for eight cycles after a pulse
    sequence s_wr_quiet;
        !REG_WR_STB [*8];
    endsequence
    sequence s_pop_quiet;
        !FIFO_POP_STB [*8];
    endsequence
    sequence s_stat_quiet;
        !STATUS_UPD_STB [*8];
    endsequence
    a_wr_one_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        REG_WR_STB |=> s_wr_quiet) else $error("write strobe too long");
    a_pop_one_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        FIFO_POP_STB |=> s_pop_quiet) else $error("pop strobe too long");
    a_stat_one_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        STATUS_UPD_STB |=> s_stat_quiet) else $error("status strobe too long");
    a_wr_value_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        !REG_WR_STB |-> $stable({REG_WR_ADDR, REG_WR_DATA})) else $error("write value moved");
    a_wr_not_nop: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
        REG_WR_STB |-> REG_WR_ADDR != ADDR_NOP_LO && REG_WR_ADDR != ADDR_NOP_HI) else $error("no-op written");
endmodule : spi_port_monitor

bind spi_slave_fifo_readback spi_port_monitor u_spi_port_monitor (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .LINK_SCLK(LINK_SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SDI(SDI), .SDO(SDO), .SDO_OE_N(SDO_OE_N),
    .REG_RD_DATA(REG_RD_DATA), .REG_WR_STB(REG_WR_STB), .REG_WR_ADDR(REG_WR_ADDR),
    .REG_WR_DATA(REG_WR_DATA), .FIFO_POP_STB(FIFO_POP_STB), .STATUS_UPD_STB(STATUS_UPD_STB));

// file: bench/spi_host_model.sv
// Serial host model running framed transfers
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    logic pin;
    // Released line shows the inverse level
    always_comb pin = sdo_oe_n ? ~sdo : sdo;
    // Idle levels
    initial begin
        sclk = 1'b0;
        sdi = 1'b0;
        // Raised after time zero so the frame marker sees the edge
        #1 cs_n = 1'b1;
    end
    task automatic xfer(input logic [31:0] word, input int edges, input bit cpol, output logic [71:0] rd);
        rd = '0;
        sclk = cpol;
        #6;
        cs_n = 1'b0;
        #3;
        for (int k = 1; k <= edges; k++) begin
            sclk = 1'b0;
            sdi = (k <= 32) ? word[32-k] : ~sdi;
            #3;
            if (k >= 9) rd = {rd[70:0], pin};
            sclk = 1'b1;
            #3;
            // Slow host after each update edge
            if (k >= 30 && (k - 30) % 24 == 0) #30;
        end
        if (!cpol) sclk = 1'b0;
        #3;
        cs_n = 1'b1;
        sdi = ~sdi;
        #6;
    endtask : xfer
endmodule : spi_host_model

// file: bench/tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb_top;
    import spi_port_pkg::*;
    logic SYS_CLK, RST_B, LINK_SCLK, CHIP_SELECT_N, SDI, SDO, SDO_OE_N, FIFO_HAS_DATA;
    logic REG_WR_STB, FIFO_POP_STB, STATUS_UPD_STB;
    logic [ADDR_W-1:0] REG_RD_ADDR, REG_WR_ADDR, a;
    logic [DATA_W-1:0] REG_RD_DATA, REG_WR_DATA, w;
    logic [DATA_W-1:0] fifo [0:7];
    logic [71:0] rd;
    int fails = 0, num_checks = 0, nwr = 0, npop = 0, nst = 0, head = 0, n, h, seed;

    spi_slave_fifo_readback u_spi_slave_fifo_readback (
        .SYS_CLK(SYS_CLK), .RST_B(RST_B), .LINK_SCLK(LINK_SCLK), .CHIP_SELECT_N(CHIP_SELECT_N), .SDI(SDI),
        .SDO(SDO), .SDO_OE_N(SDO_OE_N), .REG_RD_ADDR(REG_RD_ADDR), .REG_RD_DATA(REG_RD_DATA),
        .FIFO_HAS_DATA(FIFO_HAS_DATA), .REG_WR_STB(REG_WR_STB), .REG_WR_ADDR(REG_WR_ADDR),
        .REG_WR_DATA(REG_WR_DATA), .FIFO_POP_STB(FIFO_POP_STB), .STATUS_UPD_STB(STATUS_UPD_STB)
    );
    spi_host_model u_host (.sclk(LINK_SCLK), .cs_n(CHIP_SELECT_N), .sdi(SDI), .sdo(SDO), .sdo_oe_n(SDO_OE_N));

    function automatic logic [DATA_W-1:0] reg_word(input logic [ADDR_W-1:0] ad);
        return {ad, ad, ad, 3'h5};
    endfunction : reg_word

    // System clock
    initial begin
        SYS_CLK = 1'b0;
        forever #2 SYS_CLK = ~SYS_CLK;
    end
    // Core side: register words and sample FIFO head
    assign REG_RD_DATA = (REG_RD_ADDR == ADDR_FIFO_BURST || REG_RD_ADDR == ADDR_FIFO_NORMAL) ? fifo[head]
        : reg_word(REG_RD_ADDR);
    assign FIFO_HAS_DATA = head < 8;
    // Strobe counters and FIFO pop
    always @(posedge SYS_CLK) begin
        if (REG_WR_STB === 1'b1) nwr <= nwr + 1;
        if (STATUS_UPD_STB === 1'b1) nst <= nst + 1;
        if (FIFO_POP_STB === 1'b1) begin
            npop <= npop + 1;
            head <= head + 1;
        end
    end

    task automatic check(input string name, input logic [71:0] exp, input logic [71:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic run(input logic [7:0] cmd, input logic [23:0] d, input int edges, input bit cpol);
        u_host.xfer({cmd, d}, edges, cpol, rd);
        repeat (10) @(posedge SYS_CLK);
        #1;
    endtask : run

    task automatic results();
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Watchdog
    initial begin
        #20000;
        fails++;
        results();
    end

    initial begin
        seed = 32'hE928;
        #1 RST_B = 1'b0;
        for (int i = 0; i < 8; i++) fifo[i] = DATA_W'($random(seed));
        repeat (5) @(posedge SYS_CLK);
        #1 RST_B = 1'b1;
        @(posedge SYS_CLK);
        // Random writes in both modes, some with extra clocks
        for (int i = 0; i < 4; i++) begin
            w = DATA_W'($random(seed));
            a = ADDR_W'(2 + ($random(seed) & 31));
            n = nwr;
            run({a, 1'b0}, w, 32 + 8 * i[0], i[1]);
            check("wr_count", n + 1, nwr);
            check("wr_addr", a, REG_WR_ADDR);
            check("wr_data", w, REG_WR_DATA);
        end
        // Aborted write, no-op writes, then reads of the same places
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 7'h05 : (i == 1) ? ADDR_NOP_LO : ADDR_NOP_HI;
            n = nwr;
            run({a, 1'b0}, ~w, 32 - (i == 0), i[0]);
            check("no_wr", n, nwr);
            check("wr_kept", w, REG_WR_DATA);
            run({a, 1'b1}, 24'h000000, 32, i[1]);
            check("rd_word", (i == 0) ? reg_word(a) : ZERO_WORD, rd[23:0]);
            check("rd_addr", a, REG_RD_ADDR);
        end
        // Status read updates flags only
        n = nst;
        h = npop;
        run({ADDR_STATUS, 1'b1}, 24'h000000, 32, 1'b1);
        check("st_word", reg_word(ADDR_STATUS), rd[23:0]);
        check("st_count", n + 1, nst);
        check("st_nopop", h, npop);
        // Normal FIFO read with extra clocks
        h = head;
        n = npop;
        run({ADDR_FIFO_NORMAL, 1'b1}, 24'h000000, 40, 1'b0);
        check("fifo_rd", {fifo[h], 8'h00}, rd[31:0]);
        check("fifo_pop", n + 1, npop);
        // Three-word burst
        h = head;
        n = npop;
        run({ADDR_FIFO_BURST, 1'b1}, 24'h000000, 80, 1'b1);
        check("burst_rd", {fifo[h], fifo[h+1], fifo[h+2]}, rd);
        check("burst_pop", n + 3, npop);
        results();
    end
endmodule : tb_top
